// ### hw/rtu_pkg.sv
// constants, types and field layout for the follower-side fieldbus framer
// Behaviour
// - one start bit, eight data bits, LSB first
// - parity plus one stop, or two stops
// - baud 2400 to 115200, default even parity
// - 3.5 character silence before a frame
// - 3.5 character silence after a frame
// - frame characters sent back to back
// - gap over 1.5 characters breaks frame
// - bytes within 3.5 appended, frame rejected
// - line watched except while replying, address decoded first
// - 8-bit address, zero broadcast, own matches
// - broadcast frames never answered
// - response carries own follower address
// - function byte must be 1 to FF
// - normal response echoes function code
// - exception sets function MSB, adds code
// - data bytes 00 to FF, any count; a reply always carries at least one
// - CRC over whole frame, besides parity
// - CRC low byte first, high byte last
// - CRC mismatch discards frame, no answer
// - supported function codes are flagged
package rtu_pkg;

  // system clock and line rates
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_MIN = 2400;
  localparam int BAUD_MAX = 115200;
  localparam int BAUD_DEFAULT = 9600;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / BAUD_DEFAULT);

  // silence times in half-bit units, one character is eleven bits
  localparam int CHAR_BITS = 11;
  localparam logic [6:0] T15_HALF = 7'(CHAR_BITS * 3);
  localparam logic [6:0] T35_HALF = 7'(CHAR_BITS * 7);

  // frame contents
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] MIN_FRAME_LEN = 8'h04;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // register map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] ADDR_CFG = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_DIV = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_STAT = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_CNT = 8'h0C;

  // configuration fields
  localparam int CFG_OWN_LSB = 0;
  localparam int CFG_PAR_LSB = 8;
  localparam int CFG_EN_BIT = 16;
  localparam logic [7:0] OWN_RESET = 8'h01;
  localparam logic EN_RESET = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    PAR_EVEN = 2'h0,
    PAR_ODD = 2'h1,
    PAR_NONE = 2'h2
  } parity_t;

  localparam parity_t PAR_RESET = PAR_EVEN;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_START = 3'b001,
    CH_DATA = 3'b011,
    CH_PAR = 3'b010,
    CH_STOP = 3'b110,
    CH_STOP2 = 3'b111
  } char_state_t;

  typedef enum logic [2:0] {
    TF_IDLE = 3'b000,
    TF_ADDR = 3'b001,
    TF_FUNC = 3'b011,
    TF_DATA = 3'b010,
    TF_CRCL = 3'b110,
    TF_CRCH = 3'b111,
    TF_END = 3'b101
  } tx_frame_t;

endpackage

// ### hw/rtu_crc_byte.sv
// one-byte step of the reflected 16-bit frame check
`timescale 1ns/1ps
module rtu_crc_byte
  import rtu_pkg::*;
(
  // running value and byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] byte_in,
  // updated value
  output logic [15:0] crc_out
);

  logic [15:0] stage [0:8];

  assign stage[0] = crc_in ^ {8'h00, byte_in};

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ CRC_POLY)
                                      : (stage[i] >> 1);
    end
  endgenerate

  assign crc_out = stage[8];

endmodule

// ### hw/rtu_follower_framer.sv
// follower-side frame receiver and responder with register access
`timescale 1ns/1ps
module rtu_follower_framer
  import rtu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // register bus
  input wire logic [AXI_AW-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [AXI_AW-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  // serial line
  input wire logic rxd_in,
  output logic txd_out,
  output logic line_drive_out,
  // received frame to command handling
  output logic [7:0] cmd_byte_out,
  output logic cmd_byte_valid_out,
  output logic cmd_sof_out,
  output logic cmd_frame_ok_out,
  output logic cmd_frame_drop_out,
  output logic cmd_broadcast_out,
  output logic [7:0] cmd_func_out,
  output logic cmd_func_supported_out,
  // response from command handling
  input wire logic rsp_start_in,
  input wire logic rsp_exception_in,
  input wire logic [7:0] rsp_data_in,
  input wire logic rsp_last_in,
  input wire logic rsp_valid_in,
  output logic rsp_ready_out
);

  function automatic logic func_known(input logic [7:0] f);
    case (f)
      8'h01, 8'h03, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h0B, 8'h11:
        func_known = 1'b1;
      default: func_known = 1'b0;
    endcase
  endfunction

  // ---------------- configuration ----------------
  logic [7:0] own_q;
  parity_t par_q;
  logic en_q;
  logic [DIV_W-1:0] div_q;
  logic [15:0] ok_cnt_q;
  logic [15:0] drop_cnt_q;

  // ---------------- register bus slave ----------------
  logic aw_held_q, w_held_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go, cnt_clr;
  logic [31:0] cfg_word, wr_merge, rd_word;
  logic rd_hit;

  assign wr_go = aw_held_q && w_held_q && !axi_bvalid_out;
  assign cfg_word = {15'h0000, en_q, 6'h00, par_q, own_q};
  assign cnt_clr = wr_go && (aw_addr_q == ADDR_CNT);

  always_comb begin
    wr_merge = cfg_word;
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) begin
        wr_merge[b*8 +: 8] = w_data_q[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      axi_awready_out <= 1'b0;
      axi_wready_out <= 1'b0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= RESP_OKAY;
    end else begin
      axi_awready_out <= !aw_held_q && !(axi_awvalid_in && axi_awready_out);
      axi_wready_out <= !w_held_q && !(axi_wvalid_in && axi_wready_out);
      if (axi_awvalid_in && axi_awready_out) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= axi_awaddr_in;
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_held_q <= 1'b1;
        w_data_q <= axi_wdata_in;
        w_strb_q <= axi_wstrb_in;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        axi_bvalid_out <= 1'b1;
        axi_bresp_out <= (aw_addr_q == ADDR_CFG || aw_addr_q == ADDR_DIV ||
                          aw_addr_q == ADDR_CNT) ? RESP_OKAY : RESP_DECERR;
      end else if (axi_bready_in) begin
        axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      own_q <= OWN_RESET;
      par_q <= PAR_RESET;
      en_q <= EN_RESET;
      div_q <= DIV_RESET;
    end else if (wr_go && aw_addr_q == ADDR_CFG) begin
      own_q <= wr_merge[CFG_OWN_LSB +: 8];
      // an unused encoding falls back to the default format
      par_q <= (wr_merge[CFG_PAR_LSB +: 2] == 2'h3) ? PAR_RESET
               : parity_t'(wr_merge[CFG_PAR_LSB +: 2]);
      en_q <= wr_merge[CFG_EN_BIT];
    end else if (wr_go && aw_addr_q == ADDR_DIV) begin
      // clamp keeps the line inside the supported baud span
      if (w_data_q[DIV_W-1:0] < DIV_MIN) begin
        div_q <= DIV_MIN;
      end else if (w_data_q[DIV_W-1:0] > DIV_MAX) begin
        div_q <= DIV_MAX;
      end else begin
        div_q <= w_data_q[DIV_W-1:0];
      end
    end
  end

  // ---------------- receiver character engine ----------------
  logic rx_meta_q, rx_sync_q;
  char_state_t rx_st_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q, rx_perr_q;
  logic rc_done_q, rc_err_q;
  logic [7:0] rc_byte_q;
  logic line_drive_q;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_st_q <= CH_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rc_done_q <= 1'b0;
      rc_err_q <= 1'b0;
      rc_byte_q <= 8'h00;
    end else begin
      rc_done_q <= 1'b0;
      if (!en_q || line_drive_q) begin
        // half duplex: own echo is not taken as input
        rx_st_q <= CH_IDLE;
      end else if (rx_st_q == CH_IDLE) begin
        if (!rx_sync_q) begin
          rx_st_q <= CH_START;
          rx_cnt_q <= div_q >> 1;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= div_q - 1'b1;
        case (rx_st_q)
          CH_START: begin
            rx_st_q <= rx_sync_q ? CH_IDLE : CH_DATA;
            rx_bit_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_perr_q <= 1'b0;
          end
          CH_DATA: begin
            rx_sh_q <= {rx_sync_q, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_sync_q;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= (par_q == PAR_NONE) ? CH_STOP : CH_PAR;
            end
          end
          CH_PAR: begin
            rx_perr_q <= (rx_par_q ^ rx_sync_q) != (par_q == PAR_ODD);
            rx_st_q <= CH_STOP;
          end
          CH_STOP: begin
            // a second stop bit reads as idle line, so it is not checked
            rc_done_q <= 1'b1;
            rc_byte_q <= rx_sh_q;
            rc_err_q <= rx_perr_q || !rx_sync_q;
            rx_st_q <= CH_IDLE;
          end
          default: rx_st_q <= CH_IDLE;
        endcase
      end
    end
  end

  // ---------------- line silence timer ----------------
  logic busy;
  logic [DIV_W-1:0] ht_cnt_q;
  logic [6:0] sil_q;
  logic gap15, gap35;

  assign busy = (rx_st_q != CH_IDLE) || line_drive_q || !en_q;
  assign gap15 = sil_q > T15_HALF;
  assign gap35 = sil_q >= T35_HALF;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ht_cnt_q <= '0;
      sil_q <= 7'h00;
    end else if (busy) begin
      ht_cnt_q <= div_q >> 1;
      sil_q <= 7'h00;
    end else if (ht_cnt_q == '0) begin
      ht_cnt_q <= div_q >> 1;
      if (!gap35) begin
        sil_q <= sil_q + 7'h01;
      end
    end else begin
      ht_cnt_q <= ht_cnt_q - 1'b1;
    end
  end

  // ---------------- frame tracking ----------------
  logic synced_q, frm_act_q, frm_brk_q, frm_hit_q, gap_seen_q;
  logic [7:0] frm_len_q;
  logic [15:0] rx_crc_q, rx_crc_nx;
  logic frm_end, frm_good, take_char;

  rtu_crc_byte u_rx_crc (
    .crc_in(frm_act_q ? rx_crc_q : CRC_PRESET),
    .byte_in(rc_byte_q),
    .crc_out(rx_crc_nx)
  );

  assign take_char = rc_done_q && (frm_act_q || synced_q);
  assign frm_end = frm_act_q && gap35;
  assign frm_good = !frm_brk_q && (frm_len_q >= MIN_FRAME_LEN) &&
                    (rx_crc_q == 16'h0000) &&
                    (cmd_func_out != 8'h00);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      synced_q <= 1'b0;
      frm_act_q <= 1'b0;
      frm_brk_q <= 1'b0;
      frm_hit_q <= 1'b0;
      gap_seen_q <= 1'b0;
      frm_len_q <= 8'h00;
      rx_crc_q <= CRC_PRESET;
      cmd_byte_out <= 8'h00;
      cmd_byte_valid_out <= 1'b0;
      cmd_sof_out <= 1'b0;
      cmd_frame_ok_out <= 1'b0;
      cmd_frame_drop_out <= 1'b0;
      cmd_broadcast_out <= 1'b0;
      cmd_func_out <= 8'h00;
      cmd_func_supported_out <= 1'b0;
    end else begin
      cmd_byte_valid_out <= take_char;
      cmd_sof_out <= take_char && !frm_act_q;
      cmd_frame_ok_out <= frm_end && frm_hit_q && frm_good;
      cmd_frame_drop_out <= frm_end && frm_hit_q && !frm_good;
      if (!en_q) begin
        synced_q <= 1'b0;
        frm_act_q <= 1'b0;
      end else if (gap35) begin
        synced_q <= 1'b1;
      end
      if (frm_act_q && gap15) begin
        gap_seen_q <= 1'b1;
      end
      if (take_char) begin
        cmd_byte_out <= rc_byte_q;
        rx_crc_q <= rx_crc_nx;
        if (!frm_act_q) begin
          frm_act_q <= 1'b1;
          frm_len_q <= 8'h01;
          frm_brk_q <= rc_err_q;
          gap_seen_q <= 1'b0;
          frm_hit_q <= (rc_byte_q == own_q) ||
                       (rc_byte_q == BCAST_ADDR);
          cmd_broadcast_out <= rc_byte_q == BCAST_ADDR;
        end else begin
          // late bytes join the old frame, which then cannot pass
          frm_brk_q <= frm_brk_q || rc_err_q || gap_seen_q;
          if (frm_len_q != 8'hFF) begin
            frm_len_q <= frm_len_q + 8'h01;
          end
          if (frm_len_q == 8'h01) begin
            cmd_func_out <= rc_byte_q;
            cmd_func_supported_out <= func_known(rc_byte_q);
          end
        end
      end else if (frm_end) begin
        frm_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ok_cnt_q <= 16'h0000;
      drop_cnt_q <= 16'h0000;
    end else begin
      // a count landing in the clearing cycle is kept
      ok_cnt_q <= (cnt_clr ? 16'h0000 : ok_cnt_q) +
                  {15'h0000, cmd_frame_ok_out};
      drop_cnt_q <= (cnt_clr ? 16'h0000 : drop_cnt_q) +
                    {15'h0000, cmd_frame_drop_out};
    end
  end

  // ---------------- responder ----------------
  tx_frame_t tf_q;
  char_state_t tx_st_q;
  logic armed_q, exc_q, tx_par_q;
  logic [DIV_W-1:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q, ld_byte;
  logic [15:0] tx_crc_q, tx_crc_nx;
  logic ld_go, ld_crc;

  rtu_crc_byte u_tx_crc (
    .crc_in(tx_crc_q),
    .byte_in(ld_byte),
    .crc_out(tx_crc_nx)
  );

  always_comb begin
    ld_byte = 8'h00;
    ld_go = 1'b0;
    ld_crc = 1'b0;
    if (tx_st_q == CH_IDLE) begin
      case (tf_q)
        TF_ADDR: begin
          ld_byte = own_q;
          ld_go = 1'b1;
          ld_crc = 1'b1;
        end
        TF_FUNC: begin
          ld_byte = exc_q ? (cmd_func_out | EXC_FLAG)
                          : cmd_func_out;
          ld_go = 1'b1;
          ld_crc = 1'b1;
        end
        TF_DATA: begin
          ld_byte = rsp_data_in;
          ld_go = rsp_valid_in && rsp_ready_out;
          ld_crc = ld_go;
        end
        TF_CRCL: begin
          ld_byte = tx_crc_q[7:0];
          ld_go = 1'b1;
        end
        TF_CRCH: begin
          ld_byte = tx_crc_q[15:8];
          ld_go = 1'b1;
        end
        default: ld_go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      armed_q <= 1'b0;
      exc_q <= 1'b0;
      tf_q <= TF_IDLE;
      tx_crc_q <= CRC_PRESET;
      rsp_ready_out <= 1'b0;
      line_drive_q <= 1'b0;
    end else begin
      if (cmd_frame_ok_out && !cmd_broadcast_out) begin
        armed_q <= 1'b1;
      end else if (take_char || tf_q != TF_IDLE) begin
        armed_q <= 1'b0;
      end
      rsp_ready_out <= (tf_q == TF_DATA) && (tx_st_q == CH_IDLE) &&
                       !(rsp_valid_in && rsp_ready_out);
      if (ld_crc) begin
        tx_crc_q <= tx_crc_nx;
      end
      case (tf_q)
        TF_IDLE: begin
          // answer only after a full quiet period on the line
          if (rsp_start_in && armed_q && gap35 && !frm_act_q) begin
            tf_q <= TF_ADDR;
            exc_q <= rsp_exception_in;
            tx_crc_q <= CRC_PRESET;
            line_drive_q <= 1'b1;
          end
        end
        TF_ADDR: tf_q <= ld_go ? TF_FUNC : TF_ADDR;
        TF_FUNC: tf_q <= ld_go ? TF_DATA : TF_FUNC;
        TF_DATA: begin
          if (ld_go && rsp_last_in) begin
            tf_q <= TF_CRCL;
          end
        end
        TF_CRCL: tf_q <= ld_go ? TF_CRCH : TF_CRCL;
        TF_CRCH: tf_q <= ld_go ? TF_END : TF_CRCH;
        TF_END: begin
          if (tx_st_q == CH_IDLE) begin
            tf_q <= TF_IDLE;
            line_drive_q <= 1'b0;
          end
        end
        default: tf_q <= TF_IDLE;
      endcase
    end
  end

  assign line_drive_out = line_drive_q;

  // next byte is fetched one cycle after the stop count ends, two for data bytes: the stop bit runs one or two clocks over a bit time
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_st_q <= CH_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      txd_out <= 1'b1;
    end else if (tx_st_q == CH_IDLE) begin
      txd_out <= 1'b1;
      if (ld_go) begin
        tx_st_q <= CH_START;
        tx_sh_q <= ld_byte;
        tx_par_q <= ^ld_byte;
        tx_cnt_q <= div_q - 1'b1;
        tx_bit_q <= 3'h0;
        txd_out <= 1'b0;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else begin
      tx_cnt_q <= div_q - 1'b1;
      case (tx_st_q)
        CH_START: begin
          tx_st_q <= CH_DATA;
          txd_out <= tx_sh_q[0];
        end
        CH_DATA: begin
          tx_sh_q <= tx_sh_q >> 1;
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q != 3'h7) begin
            txd_out <= tx_sh_q[1];
          end else if (par_q == PAR_NONE) begin
            tx_st_q <= CH_STOP2;
            txd_out <= 1'b1;
          end else begin
            tx_st_q <= CH_PAR;
            txd_out <= tx_par_q ^ (par_q == PAR_ODD);
          end
        end
        CH_PAR: begin
          tx_st_q <= CH_STOP;
          txd_out <= 1'b1;
        end
        CH_STOP2: begin
          tx_st_q <= CH_STOP;
          txd_out <= 1'b1;
        end
        CH_STOP: tx_st_q <= CH_IDLE;
        default: tx_st_q <= CH_IDLE;
      endcase
    end
  end

  // ---------------- read channel ----------------
  always_comb begin
    rd_hit = 1'b1;
    case (axi_araddr_in)
      ADDR_CFG: rd_word = cfg_word;
      ADDR_DIV: rd_word = {{(32-DIV_W){1'b0}}, div_q};
      ADDR_STAT: rd_word = {24'h000000, cmd_func_out[3:0], armed_q,
                            line_drive_q, frm_act_q, synced_q};
      ADDR_CNT: rd_word = {drop_cnt_q, ok_cnt_q};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      axi_arready_out <= 1'b0;
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h0000_0000;
      axi_rresp_out <= RESP_OKAY;
    end else begin
      axi_arready_out <= !axi_rvalid_out &&
                         !(axi_arvalid_in && axi_arready_out);
      if (axi_arvalid_in && axi_arready_out) begin
        axi_rvalid_out <= 1'b1;
        axi_rdata_out <= rd_word;
        axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (axi_rready_in) begin
        axi_rvalid_out <= 1'b0;
      end
    end
  end

endmodule

// ### sim/rtu_follower_framer_props.sv
// assertions on the framer's bus, line and reply ports
`timescale 1ns/1ps
module rtu_follower_framer_props (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // watched ports
  input wire logic axi_awready_out,
  input wire logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic axi_arready_out,
  input wire logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic txd_out,
  input wire logic line_drive_out,
  input wire logic cmd_byte_valid_out,
  input wire logic cmd_sof_out,
  input wire logic cmd_frame_ok_out,
  input wire logic cmd_frame_drop_out,
  input wire logic cmd_broadcast_out,
  input wire logic rsp_start_in
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  property p_b_done;
    axi_bvalid_out && axi_bready_in |=> !axi_bvalid_out;
  endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid stayed");
  property p_r_done;
    axi_rvalid_out && axi_rready_in |=> !axi_rvalid_out;
  endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid stayed");
  property p_aw_hold;
    axi_bvalid_out |-> !axi_awready_out;
  endproperty
  a_aw_hold: assert property (p_aw_hold) else $error("awready early");
  property p_ar_hold;
    axi_rvalid_out |-> !axi_arready_out;
  endproperty
  a_ar_hold: assert property (p_ar_hold) else $error("arready early");
  property p_txd_idle;
    !line_drive_out |-> txd_out;
  endproperty
  a_txd_idle: assert property (p_txd_idle) else $error("txd not idle");
  property p_drive_src;
    $rose(line_drive_out) |-> $past(rsp_start_in) || $past(rsp_start_in, 2);
  endproperty
  a_drive_src: assert property (p_drive_src) else $error("drive unasked");
  property p_start_bit;
    $rose(line_drive_out) |-> ##[0:1] !txd_out;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");
  property p_bcast;
    cmd_broadcast_out && rsp_start_in && !line_drive_out
      |=> !line_drive_out [*2];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");
  property p_sof;
    cmd_sof_out |-> cmd_byte_valid_out;
  endproperty
  a_sof: assert property (p_sof) else $error("sof without byte");
  property p_one_end;
    !(cmd_frame_ok_out && cmd_frame_drop_out);
  endproperty
  a_one_end: assert property (p_one_end) else $error("ok and drop");
endmodule

// ### sim/rtu_line_master.sv
// line-side model of the bus master: sends queries, captures replies
`timescale 1ns/1ps
module rtu_line_master #(parameter int BIT = 217) (
  input wire logic clk_in,
  input wire logic txd_in,
  input wire logic drive_in,
  output logic rxd_out
);
  logic line_q = 1'b1;
  logic [8:0] sh;
  logic [7:0] rx_q[$];
  int par_errs = 0;
  // fail-safe bias holds the bus high when nobody drives
  assign rxd_out = line_q & (drive_in ? txd_in : 1'b1);
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic put_bit(input logic b);
    @(posedge clk_in);
    line_q <= b;
    repeat (BIT - 1) @(posedge clk_in);
  endtask
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      put_bit(1'b0);
      for (int k = 0; k < 8; k++) put_bit(q[i][k]);
      put_bit(^q[i]);
      put_bit(1'b1);
    end
    // 39 bit times of quiet, just over 3.5 characters, keeps runs short
    repeat (39 * BIT) @(posedge clk_in);
  endtask
  always begin
    @(posedge clk_in);
    if (drive_in && !txd_in) begin
      repeat (BIT / 2) @(posedge clk_in);
      for (int k = 0; k < 9; k++) begin
        repeat (BIT) @(posedge clk_in);
        sh[k] = txd_in;
      end
      rx_q.push_back(sh[7:0]);
      if (^sh) par_errs++;
      // wait into the stop bit so a low parity bit is not a new start
      repeat (BIT) @(posedge clk_in);
    end
  end
endmodule

// ### sim/rtu_follower_framer_tb.sv
// self-checking bench: bus set-up, queries from the line model, replies
`timescale 1ns/1ps
module rtu_follower_framer_tb;
  import rtu_pkg::*;
  `define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [AXI_AW-1:0] axi_awaddr_in = '0, axi_araddr_in = '0;
  logic [31:0] axi_wdata_in = '0;
  logic [3:0] axi_wstrb_in = 4'hF;
  logic axi_awvalid_in = 1'b0, axi_wvalid_in = 1'b0, axi_bready_in = 1'b0;
  logic axi_arvalid_in = 1'b0, axi_rready_in = 1'b0, rsp_start_in = 1'b0;
  logic rsp_exception_in = 1'b0, rsp_last_in = 1'b1, rsp_valid_in = 1'b0;
  logic [7:0] rsp_data_in = 8'h00;
  logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out;
  logic axi_rvalid_out, rxd_in, txd_out, line_drive_out, cmd_byte_valid_out;
  logic cmd_sof_out, cmd_frame_ok_out, cmd_frame_drop_out, cmd_broadcast_out;
  logic cmd_func_supported_out, rsp_ready_out;
  logic [1:0] axi_bresp_out, axi_rresp_out, rr;
  logic [31:0] axi_rdata_out, rd;
  logic [7:0] cmd_byte_out, cmd_func_out;
  logic [7:0] exp_q[$];
  logic [15:0] c;
  int bad_count = 0, n_checks = 0, ok_n = 0, drop_n = 0, drv_n = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  rtu_follower_framer u_dut (.*);
  rtu_line_master u_master (.clk_in(sys_clk_in), .txd_in(txd_out),
    .drive_in(line_drive_out), .rxd_out(rxd_in));
  always @(posedge sys_clk_in) begin
    ok_n <= ok_n + int'(cmd_frame_ok_out === 1'b1);
    drop_n <= drop_n + int'(cmd_frame_drop_out === 1'b1);
    drv_n <= drv_n + int'($rose(line_drive_out));
  end
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1'b1;
    axi_wvalid_in <= 1'b1;
    axi_bready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (axi_awready_out) axi_awvalid_in <= 1'b0;
      if (axi_wready_out) axi_wvalid_in <= 1'b0;
    end while (axi_bvalid_out !== 1'b1);
    axi_bready_in <= 1'b0;
  endtask
  task automatic axi_rd(input logic [AXI_AW-1:0] a);
    @(posedge sys_clk_in);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'b1;
    axi_rready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (axi_arready_out) axi_arvalid_in <= 1'b0;
    end while (axi_rvalid_out !== 1'b1);
    rd = axi_rdata_out;
    rr = axi_rresp_out;
    axi_rready_in <= 1'b0;
  endtask
  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (104000) @(posedge sys_clk_in);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    axi_rd(ADDR_CFG);
    `CHK("cfg", 32'h0001_0001, rd)
    axi_rd(ADDR_DIV);
    `CHK("div", {16'h0000, DIV_RESET}, rd)
    // a too-small divider clamps to the fastest rate, which keeps runs short
    axi_wr(ADDR_DIV, 32'h0000_0001);
    axi_rd(ADDR_DIV);
    `CHK("div min", {16'h0000, DIV_MIN}, rd)
    axi_rd(8'h10);
    `CHK("unmapped", RESP_DECERR, rr)
    axi_wr(8'h10, 32'h0000_0000);
    `CHK("wr unmapped", RESP_DECERR, axi_bresp_out)
    repeat (44 * 217) @(posedge sys_clk_in);
    u_master.send('{8'h01, 8'h03}, 1'b0);
    `CHK("ok", 1, ok_n)
    `CHK("func", 8'h03, cmd_func_out)
    `CHK("supported", 1'b1, cmd_func_supported_out)
    @(posedge sys_clk_in);
    rsp_start_in <= 1'b1;
    rsp_exception_in <= 1'b1;
    rsp_valid_in <= 1'b1;
    rsp_data_in <= 8'h02;
    @(posedge sys_clk_in);
    rsp_start_in <= 1'b0;
    do @(posedge sys_clk_in); while (rsp_ready_out !== 1'b1);
    rsp_valid_in <= 1'b0;
    do @(posedge sys_clk_in); while (line_drive_out === 1'b1);
    exp_q = '{8'h01, 8'h83, 8'h02};
    c = u_master.crc16(exp_q);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
    `CHK("reply len", 5, u_master.rx_q.size())
    foreach (exp_q[i]) `CHK("reply", exp_q[i], u_master.rx_q[i])
    `CHK("parity", 0, u_master.par_errs)
    repeat (39 * 217) @(posedge sys_clk_in);
    u_master.send('{8'h00, 8'h06}, 1'b0);
    `CHK("bcast ok", 2, ok_n)
    `CHK("bcast", 1'b1, cmd_broadcast_out)
    @(posedge sys_clk_in);
    rsp_start_in <= 1'b1;
    @(posedge sys_clk_in);
    rsp_start_in <= 1'b0;
    repeat (300) @(posedge sys_clk_in);
    `CHK("bcast quiet", 1, drv_n)
    u_master.send('{8'h01, 8'h10}, 1'b1);
    `CHK("drop", 1, drop_n)
    u_master.send('{8'h05, 8'h01}, 1'b0);
    `CHK("other ok", 2, ok_n)
    `CHK("other drop", 1, drop_n)
    `CHK("byte", u_master.crc16('{8'h05, 8'h01}) >> 8, cmd_byte_out)
    complete_run();
  end
endmodule
bind rtu_follower_framer rtu_follower_framer_props u_props (.*);
